// *** hw/external_alarm_io.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "alarm_io_defs.svh"

// Function
// (R1) two alarm input channels and four relay output channels
// (R2) an input raises local major/minor alarm or feeds the far end
// (R3) input polarity: active with current (default) or without current
// (R4) each output follows one selected local, remote or remote-input source
// (R5) relay closes on active or inactive alarm; inactive-closes by default
// (R6) protection mode reserves input 2; it raises no user alarm
// (R7) input states always forwarded to the far end
// (R8) far end logs a received input only when mapped to an output
// (R9) local report enable, default off, gates local alarm and logging
// (R10) severity minor (default) or major, used only when reporting
// (R11) protection mode reserves output 4 from user mapping
// (R12) none, test major and test minor selections; test is not logged
// (R13) inputs synchronised before polarity, report and forward logic
// (R14) output state from selected source, then relay polarity applied
module external_alarm_io #(
  parameter int N_IN = `IN_CHANNELS, // R1
  parameter int N_OUT = `OUT_CHANNELS // R1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // contact inputs, high while current flows
  input wire logic [N_IN-1:0] contact_current,
  // input configuration
  input wire logic [N_IN-1:0] in_active_no_current,
  input wire logic [N_IN-1:0] in_report_en,
  input wire logic [N_IN-1:0] in_severity_major,
  input wire logic protection_switching_mode,
  // output configuration
  input wire logic [N_OUT*`SRC_SEL_WIDTH-1:0] out_src_sel,
  input wire logic [N_OUT-1:0] relay_closed_when_inactive,
  // other local alarm causes and far-end state
  input wire logic sys_major_alarm,
  input wire logic sys_minor_alarm,
  input wire logic remote_major_alarm,
  input wire logic remote_minor_alarm,
  input wire logic [1:0] remote_input_state,
  // input results
  output logic [N_IN-1:0] in_state,
  output logic [N_IN-1:0] tx_input_state,
  output logic [N_IN-1:0] in_log_event,
  output logic prot_switch_ctrl,
  output logic local_major_alarm,
  output logic local_minor_alarm,
  // remote input logging
  output logic [1:0] remote_in_log,
  // relays
  output logic [N_OUT-1:0] relay_close,
  output logic [N_OUT-1:0] out_active,
  output logic [N_OUT-1:0] out_is_test
);
  import alarm_io_pkg::*;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // synchroniser chain and filtered level
  logic [N_IN-1:0] sync1_ff;
  logic [N_IN-1:0] sync2_ff;
  logic [N_IN-1:0] sync3_ff;
  logic [N_IN-1:0] stable_ff;
  // decoded input levels
  logic [N_IN-1:0] user_in;
  logic [N_IN-1:0] active_in;
  logic [N_IN-1:0] prev_report_ff;
  // local alarm next values
  logic nxt_major;
  logic nxt_minor;

  // three stages; a change is taken once stages two and three agree
  // reset loads the inactive contact level, so release fakes no alarm edge;
  // a contact that is really active then shows as a genuine rise
  // limitation: a contact pulse shorter than two edges is filtered away
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sync1_ff <= in_active_no_current;
      sync2_ff <= in_active_no_current;
      sync3_ff <= in_active_no_current;
    end
    else
    begin
      sync1_ff <= contact_current; // R13
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // filtered contact level; holds when the last two stages disagree
  genvar i;
  generate
    for (i = 0; i < N_IN; i = i + 1)
    begin : g_in
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
          stable_ff[i] <= in_active_no_current[i]; // R3
        else if (sync2_ff[i] == sync3_ff[i])
          stable_ff[i] <= sync3_ff[i]; // R13
      end
      // polarity after synchronising
      assign active_in[i] = stable_ff[i] ^ in_active_no_current[i]; // R3
      // protected input raises no user alarm
      assign user_in[i] = active_in[i] &&
                          !(protection_switching_mode && (i == `PROT_IN_IDX)); // R6
    end
  endgenerate

  // ****************************************************************
  // local alarm generation and forwarding
  // ****************************************************************
  // severity only matters while reporting is on
  always_comb
  begin
    nxt_major = sys_major_alarm || |(user_in & in_report_en & in_severity_major); // R2 R9 R10
    nxt_minor = sys_minor_alarm || |(user_in & in_report_en & ~in_severity_major); // R10
  end

  // registered results; forwarding ignores report and severity settings
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      in_state <= '0;
      tx_input_state <= '0;
      local_major_alarm <= 1'b0;
      local_minor_alarm <= 1'b0;
      prot_switch_ctrl <= 1'b0;
    end
    else
    begin
      in_state <= user_in;
      tx_input_state <= active_in; // R7
      local_major_alarm <= nxt_major; // R9
      local_minor_alarm <= nxt_minor; // R9
      prot_switch_ctrl <= protection_switching_mode && active_in[`PROT_IN_IDX]; // R6
    end
  end

  // one-cycle log event on each rise of a reported user alarm
  // enabling the report while the input is already active logs it at once
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prev_report_ff <= '0;
      in_log_event <= '0;
    end
    else
    begin
      prev_report_ff <= user_in & in_report_en;
      in_log_event <= user_in & in_report_en & ~prev_report_ff; // R9
    end
  end

  // ****************************************************************
  // remote input logging
  // ****************************************************************
  logic [1:0] rin_mapped;

  // a remote input is logged only while some usable output maps it
  // the protected output never counts as a mapping in protection mode
  always_comb
  begin
    rin_mapped = 2'h0;
    for (int k = 0; k < N_OUT; k++)
    begin
      if (!(protection_switching_mode && k == `PROT_OUT_IDX))
      begin
        if (out_src_sel[k*`SRC_SEL_WIDTH +: `SRC_SEL_WIDTH] == SRC_REMOTE_IN1)
          rin_mapped[0] = 1'b1; // R8
        if (out_src_sel[k*`SRC_SEL_WIDTH +: `SRC_SEL_WIDTH] == SRC_REMOTE_IN2)
          rin_mapped[1] = 1'b1; // R8
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      remote_in_log <= 2'h0;
    else
      remote_in_log <= remote_input_state & rin_mapped; // R8
  end

  // ****************************************************************
  // output relays
  // ****************************************************************
  // sources gathered for the output driver; remote inputs come straight in
  alarm_src_if srcs ();
  assign srcs.src.local_major = local_major_alarm;
  assign srcs.src.local_minor = local_minor_alarm;
  assign srcs.src.remote_major = remote_major_alarm;
  assign srcs.src.remote_minor = remote_minor_alarm;
  assign srcs.src.remote_in1 = remote_input_state[0];
  assign srcs.src.remote_in2 = remote_input_state[1];
  assign srcs.prot_mode = protection_switching_mode;

  // one driver covers all channels; channel counts come from the parameters
  alarm_out_drive #(.N_OUT(N_OUT)) u_drive ( // R1
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .srcs(srcs.consumer),
    .out_src_sel(out_src_sel),
    .relay_closed_when_inactive(relay_closed_when_inactive),
    .relay_close(relay_close),
    .out_active(out_active),
    .out_is_test(out_is_test)
  );

endmodule : external_alarm_io

`default_nettype wire

// *** hw/alarm_io_defs.svh ***
`ifndef ALARM_IO_DEFS_SVH
`define ALARM_IO_DEFS_SVH

// ****************************************************************
// channel counts
// ****************************************************************
`define IN_CHANNELS 2
`define OUT_CHANNELS 4
// input 2 and output 4 are taken over by protection switching
`define PROT_IN_IDX 1
`define PROT_OUT_IDX 3

// ****************************************************************
// source select field
// ****************************************************************
`define SRC_SEL_WIDTH 4
// mapping table of each output, reset value is none
`define SRC_SEL_RESET 4'h0

// ****************************************************************
// per-bit reset values of the configuration inputs
// ****************************************************************
// source-on polarity: 0 = active while current flows
`define IN_POL_RESET 1'b0
// relay closes while alarm inactive: 1
`define RELAY_POL_RESET 1'b1
`define REPORT_EN_RESET 1'b0
// severity 0 = minor
`define SEVERITY_RESET 1'b0

`endif

// *** hw/alarm_io_pkg.sv ***
package alarm_io_pkg;

  // output source selection
  typedef enum logic [3:0] {
    SRC_NONE = 4'h0,
    SRC_LOCAL_MAJOR = 4'h1,
    SRC_LOCAL_MINOR = 4'h2,
    SRC_REMOTE_MAJOR = 4'h3,
    SRC_REMOTE_MINOR = 4'h4,
    SRC_REMOTE_IN1 = 4'h5,
    SRC_REMOTE_IN2 = 4'h6,
    SRC_TEST_MAJOR = 4'h7,
    SRC_TEST_MINOR = 4'h8
  } src_sel_type;

  // alarm sources presented to every output channel
  typedef struct packed {
    logic local_major;
    logic local_minor;
    logic remote_major;
    logic remote_minor;
    logic remote_in1;
    logic remote_in2;
  } alarm_src_type;

endpackage : alarm_io_pkg

// *** hw/alarm_src_if.sv ***
`timescale 1ns/100ps
`default_nettype none

// carries the alarm sources from the top to the output driver
interface alarm_src_if;
  import alarm_io_pkg::*;
  alarm_src_type src;
  logic prot_mode;
  modport provider (output src, output prot_mode);
  modport consumer (input src, input prot_mode);
endinterface : alarm_src_if

`default_nettype wire

// *** hw/alarm_out_drive.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "alarm_io_defs.svh"

// ****************************************************************
// output relay driver for all output channels
// ****************************************************************
module alarm_out_drive #(
  parameter int N_OUT = `OUT_CHANNELS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // alarm sources
  alarm_src_if.consumer srcs,
  // configuration
  input wire logic [N_OUT*`SRC_SEL_WIDTH-1:0] out_src_sel,
  input wire logic [N_OUT-1:0] relay_closed_when_inactive,
  // relay drive and test flags
  output logic [N_OUT-1:0] relay_close,
  output logic [N_OUT-1:0] out_active,
  output logic [N_OUT-1:0] out_is_test
);
  import alarm_io_pkg::*;

  genvar g;
  generate
    for (g = 0; g < N_OUT; g = g + 1)
    begin : g_out
      logic act;
      logic usable;
      src_sel_type sel;
      assign sel = src_sel_type'(out_src_sel[g*`SRC_SEL_WIDTH +: `SRC_SEL_WIDTH]); // R4
      // protected output is withheld from user mapping
      assign usable = !(srcs.prot_mode && (g == `PROT_OUT_IDX)); // R11

      // source mux; test codes drive the relay but are not real alarms
      always_comb
      begin
        case (sel)
          SRC_LOCAL_MAJOR: act = srcs.src.local_major; // R4
          SRC_LOCAL_MINOR: act = srcs.src.local_minor;
          SRC_REMOTE_MAJOR: act = srcs.src.remote_major;
          SRC_REMOTE_MINOR: act = srcs.src.remote_minor;
          SRC_REMOTE_IN1: act = srcs.src.remote_in1;
          SRC_REMOTE_IN2: act = srcs.src.remote_in2;
          SRC_TEST_MAJOR: act = 1'b1; // R12
          SRC_TEST_MINOR: act = 1'b1; // R12
          default: act = 1'b0;
        endcase
      end

      // registered relay drive; reset clears out_active and closes every relay, whatever relay_closed_when_inactive holds
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          out_active[g] <= 1'b0;
          out_is_test[g] <= 1'b0;
          relay_close[g] <= `RELAY_POL_RESET; // R5
        end
        else
        begin
          out_active[g] <= usable && act; // R14
          out_is_test[g] <= usable && (sel == SRC_TEST_MAJOR || sel == SRC_TEST_MINOR); // R12
          relay_close[g] <= (usable && act) ^ relay_closed_when_inactive[g]; // R5 R14
        end
      end
    end
  endgenerate

endmodule : alarm_out_drive

`default_nettype wire

// *** test/alarm_io_chk_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// port relation checks
// ****
module alarm_io_chk
  import alarm_io_pkg::*;
#(
  parameter int N_IN = 2,
  parameter int N_OUT = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // stimulus side
  input wire logic [N_IN-1:0] contact_current,
  input wire logic [N_IN-1:0] in_active_no_current,
  input wire logic [N_IN-1:0] in_report_en,
  input wire logic [N_IN-1:0] in_severity_major,
  input wire logic protection_switching_mode,
  input wire logic [N_OUT*4-1:0] out_src_sel,
  input wire logic [N_OUT-1:0] relay_closed_when_inactive,
  input wire logic sys_major_alarm,
  input wire logic sys_minor_alarm,
  input wire logic remote_major_alarm,
  input wire logic remote_minor_alarm,
  input wire logic [1:0] remote_input_state,
  // results
  input wire logic [N_IN-1:0] in_state,
  input wire logic [N_IN-1:0] tx_input_state,
  input wire logic [N_IN-1:0] in_log_event,
  input wire logic prot_switch_ctrl,
  input wire logic local_major_alarm,
  input wire logic local_minor_alarm,
  input wire logic [1:0] remote_in_log,
  input wire logic [N_OUT-1:0] relay_close,
  input wire logic [N_OUT-1:0] out_active,
  input wire logic [N_OUT-1:0] out_is_test
);
  logic [N_OUT-1:0] exp_act_ff, exp_tst_ff;
  logic [1:0] exp_log_ff;
  logic [2:0] cnt_ff;
  wire logic [N_OUT-1:0] use_ok = {!protection_switching_mode, {(N_OUT-1){1'b1}}};
  // unknown codes read as none, so they simply never hit
  function automatic logic hit(input logic [3:0] s);
    hit = (s == 4'h1 && local_major_alarm) || (s == 4'h2 && local_minor_alarm) ||
      (s == 4'h3 && remote_major_alarm) || (s == 4'h4 && remote_minor_alarm) ||
      (s == 4'h5 && remote_input_state[0]) || (s == 4'h6 && remote_input_state[1]) ||
      s == 4'h7 || s == 4'h8;
  endfunction : hit
  // expected output state, one edge behind its sources
  always_ff @(posedge ref_clk)
  begin
    exp_log_ff <= 2'h0;
    for (int k = 0; k < N_OUT; k++)
    begin
      exp_act_ff[k] <= use_ok[k] && hit(out_src_sel[4*k+:4]);
      exp_tst_ff[k] <= use_ok[k] && out_src_sel[4*k+:4] inside {4'h7, 4'h8};
      if (use_ok[k] && out_src_sel[4*k+:4] == 4'h5)
        exp_log_ff[0] <= remote_input_state[0];
    end
    for (int k = 0; k < N_OUT; k++)
    begin
      if (use_ok[k] && out_src_sel[4*k+:4] == 4'h6)
        exp_log_ff[1] <= remote_input_state[1];
    end
  end
  // edges since reset; the input path needs five before it is settled
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      cnt_ff <= 3'h0;
    else if (cnt_ff != 3'h7)
      cnt_ff <= cnt_ff + 3'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_pulse;
    in_state[0] ##1 !in_log_event[0];
  endsequence
  a_fwd_state: assert property (cnt_ff == 3'h7 |->
    tx_input_state == ($past(contact_current, 5) ^ $past(in_active_no_current)))
    else $error("forwarded input state wrong");
  a_prot_mask: assert property ($past(rst_n) |->
    in_state == (tx_input_state & {!$past(protection_switching_mode), 1'b1}))
    else $error("user input state not masked");
  a_prot_ctrl: assert property ($past(rst_n) |->
    prot_switch_ctrl == (tx_input_state[1] && $past(protection_switching_mode)))
    else $error("protection control wrong");
  a_minor_alm: assert property ($past(rst_n) |-> local_minor_alarm ==
    ($past(sys_minor_alarm) || |(in_state & $past(in_report_en) & ~$past(in_severity_major))))
    else $error("local minor alarm wrong");
  a_major_alm: assert property ($past(rst_n) |-> local_major_alarm ==
    ($past(sys_major_alarm) || |(in_state & $past(in_report_en) & $past(in_severity_major))))
    else $error("local major alarm wrong");
  a_log_rise: assert property ($past(rst_n) && $rose(in_state[0]) &&
    $past(in_report_en[0]) |-> in_log_event[0]) else $error("log event missing");
  a_log_pulse: assert property (in_log_event[0] |-> s_pulse)
    else $error("log event not a single pulse");
  a_out_map: assert property ($past(rst_n) |-> out_active == exp_act_ff)
    else $error("output state wrong");
  a_test_flag: assert property ($past(rst_n) |-> out_is_test == exp_tst_ff)
    else $error("test flag wrong");
  a_relay_pol: assert property ($past(rst_n) |->
    relay_close == (out_active ^ $past(relay_closed_when_inactive)))
    else $error("relay polarity wrong");
  a_rem_log: assert property ($past(rst_n) |-> remote_in_log == exp_log_ff)
    else $error("remote input logging wrong");
endmodule : alarm_io_chk
bind external_alarm_io alarm_io_chk #(.N_IN(N_IN), .N_OUT(N_OUT)) chk_u (.*);
`default_nettype wire

// *** test/far_end_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// contact equipment and far-end terminal
// ****
module far_end_model (
  // clock
  input wire logic ref_clk,
  // contact level, high while current flows
  output logic [1:0] contact_current,
  // far-end alarm state
  output logic remote_major_alarm,
  output logic remote_minor_alarm,
  output logic [1:0] remote_input_state
);
  initial
  begin
    contact_current = 2'h0;
    {remote_major_alarm, remote_minor_alarm, remote_input_state} = 4'h0;
  end
  // levels move just after an edge and are held, so no glitch reaches the filter
  task automatic set_contact(input logic [1:0] v);
    @(posedge ref_clk);
    contact_current <= v;
  endtask : set_contact
  task automatic set_remote(input logic [3:0] v);
    @(posedge ref_clk);
    {remote_major_alarm, remote_minor_alarm, remote_input_state} <= v;
  endtask : set_remote
endmodule : far_end_model
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// alarm contact bench
// ****
module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] contact_current, remote_input_state, in_state, tx_input_state, in_log_event;
  logic [1:0] remote_in_log;
  logic [1:0] in_active_no_current, in_report_en, in_severity_major;
  logic protection_switching_mode, sys_major_alarm, sys_minor_alarm;
  logic remote_major_alarm, remote_minor_alarm, prot_switch_ctrl;
  logic local_major_alarm, local_minor_alarm;
  logic [15:0] out_src_sel;
  logic [3:0] relay_closed_when_inactive, relay_close, out_active, out_is_test;
  int error_cnt = 0;
  int n_tests = 0;
  initial forever #25 ref_clk = ~ref_clk;
  far_end_model far_u (.ref_clk(ref_clk), .contact_current(contact_current),
    .remote_major_alarm(remote_major_alarm), .remote_minor_alarm(remote_minor_alarm),
    .remote_input_state(remote_input_state));
  external_alarm_io dut_u (.*);
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // look at the falling edge, where registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : wt
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic t_pol();
    far_u.set_contact(2'h1);
    wt(7);
    chk("tx_input_state", tx_input_state, 2'h1);
    chk("in_state", in_state, 2'h1);
    chk("local_minor_alarm", local_minor_alarm, 1'b0);
    @(posedge ref_clk);
    in_active_no_current <= 2'h3;
    wt(2);
    chk("tx_input_state", tx_input_state, 2'h2);
    @(posedge ref_clk);
    in_active_no_current <= 2'h0;
    far_u.set_contact(2'h0);
    wt(7);
    $display("polarity test done");
  endtask : t_pol
  task automatic t_rep();
    @(posedge ref_clk);
    in_report_en <= 2'h3;
    in_severity_major <= 2'h2;
    far_u.set_contact(2'h3);
    wt(5);
    chk("in_log_event", in_log_event, 2'h3);
    wt(1);
    chk("in_log_event", in_log_event, 2'h0);
    chk("local_minor_alarm", local_minor_alarm, 1'b1);
    chk("local_major_alarm", local_major_alarm, 1'b1);
    @(posedge ref_clk);
    in_report_en <= 2'h1;
    wt(2);
    chk("local_major_alarm", local_major_alarm, 1'b0);
    @(posedge ref_clk);
    sys_major_alarm <= 1'b1;
    wt(1);
    chk("local_major_alarm", local_major_alarm, 1'b1);
    @(posedge ref_clk);
    sys_major_alarm <= 1'b0;
    wt(1);
    chk("local_major_alarm", local_major_alarm, 1'b0);
    $display("report test done");
  endtask : t_rep
  task automatic t_prot();
    @(posedge ref_clk);
    protection_switching_mode <= 1'b1;
    in_report_en <= 2'h3;
    out_src_sel <= 16'h3000;
    far_u.set_remote(4'h8);
    wt(3);
    chk("in_state", in_state, 2'h1);
    chk("prot_switch_ctrl", prot_switch_ctrl, 1'b1);
    chk("tx_input_state", tx_input_state, 2'h3);
    chk("local_major_alarm", local_major_alarm, 1'b0);
    chk("relay_close", relay_close, 4'hf);
    @(posedge ref_clk);
    protection_switching_mode <= 1'b0;
    wt(3);
    chk("out_active", out_active, 4'h8);
    chk("relay_close", relay_close, 4'h7);
    @(posedge ref_clk);
    in_report_en <= 2'h0;
    far_u.set_contact(2'h0);
    far_u.set_remote(4'h0);
    wt(7);
    $display("protection test done");
  endtask : t_prot
  task automatic t_map();
    logic [15:0] exp_map;
    exp_map = 16'h1ac;
    @(posedge ref_clk);
    relay_closed_when_inactive <= 4'he;
    sys_minor_alarm <= 1'b1;
    far_u.set_remote(4'h9);
    wt(3);
    for (int c = 0; c < 10; c++)
    begin
      @(posedge ref_clk);
      out_src_sel <= 16'(c);
      wt(2);
      chk("out_active", out_active[0], exp_map[c]);
      chk("relay_close", relay_close[0], exp_map[c]);
      chk("out_is_test", out_is_test[0], c == 7 || c == 8);
    end
    $display("mapping test done");
  endtask : t_map
  task automatic t_rlog();
    @(posedge ref_clk);
    protection_switching_mode <= 1'b1;
    out_src_sel <= 16'h6050;
    far_u.set_remote(4'h3);
    wt(2);
    chk("remote_in_log", remote_in_log, 2'h1);
    @(posedge ref_clk);
    protection_switching_mode <= 1'b0;
    wt(2);
    chk("remote_in_log", remote_in_log, 2'h3);
    $display("remote log test done");
  endtask : t_rlog
  // main sequence; reset outputs are looked at before release
  initial
  begin
    // configuration at its documented defaults before the first edge
    in_active_no_current <= 2'h0;
    in_report_en <= 2'h0;
    in_severity_major <= 2'h0;
    protection_switching_mode <= 1'b0;
    sys_major_alarm <= 1'b0;
    sys_minor_alarm <= 1'b0;
    out_src_sel <= 16'h0;
    relay_closed_when_inactive <= 4'hf;
    repeat (11) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("relay_close", relay_close, 4'hf);
    chk("out_active", out_active, 4'h0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    t_pol();
    t_rep();
    t_prot();
    t_map();
    t_rlog();
    end_sim();
  end
  // hang guard
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    $display("timeout");
    end_sim();
  end
endmodule : tb
`default_nettype wire
